// ===== dsrs_params.svh
// constants for the speed reference select block
`ifndef DSRS_PARAMS_SVH
`define DSRS_PARAMS_SVH

`define DSRS_FW            16
`define DSRS_REF_MAX       16'h01F4
`define DSRS_REF_ZERO      16'h0000

`define DSRS_IDX_SRC       6'h00
`define DSRS_IDX_POT       6'h01
`define DSRS_IDX_PRESET    6'h02
`define DSRS_IDX_BAND      6'h09
`define DSRS_IDX_STATUS    6'h0C
`define DSRS_IDX_POTVAL    6'h0D
`define DSRS_NUM_PRESET    7
`define DSRS_NUM_BAND      3

`define DSRS_SEL0_LSB      0
`define DSRS_SEL1_LSB      4
`define DSRS_SEL2_LSB      8
`define DSRS_INC_LSB       12
`define DSRS_DEC_LSB       16
`define DSRS_MODE_LSB      0
`define DSRS_PLACE_LSB     4
`define DSRS_RAMP_LSB      16

`define DSRS_SRC_RST       32'h0000_0000
`define DSRS_POT_RST       32'h0064_0000
`define DSRS_PRESET1_RST   16'h0064
`define DSRS_PRESET2_RST   16'h00C8
`define DSRS_PRESET3_RST   16'h00FA
`define DSRS_PRESET4_RST   16'h012C
`define DSRS_PRESET5_RST   16'h0190
`define DSRS_PRESET6_RST   16'h01C2
`define DSRS_PRESET7_RST   16'h01F4
`define DSRS_BAND_RST      32'h0000_0000

`define DSRS_PLACE_POT     3'h5
`define DSRS_MODE_RESET    2'h0
`define DSRS_MODE_KEEP     2'h1
`define DSRS_MODE_TRACK    2'h2
`define DSRS_MODE_FREE     2'h3
`define DSRS_RAMP_MIN      16'h0001
`define DSRS_RAMP_MAX      16'h0C80

`define DSRS_RAMP_UNIT_NS  100000000
`define DSRS_CLK_NS        40

`endif

// ===== dsrs_pkg.sv
// types and band test shared by the speed reference select block
package dsrs_pkg;

  typedef struct packed {
    logic [15:0] hi;
    logic [15:0] lo;
  } dsrs_band_type;

  typedef struct packed {
    logic [15:0] value;
    logic        hit;
  } dsrs_skip_type;

  // strictly inside: the band edges themselves are legal settling points
  function automatic logic dsrs_in_band(input logic [15:0] x, input dsrs_band_type b);
    dsrs_in_band = (b.lo < b.hi) && (x > b.lo) && (x < b.hi);
  endfunction

endpackage

// ===== dsrs_skip.sv
// skip band suppression over the union of up to three bands
`timescale 1ns/1ps
module dsrs_skip
  import dsrs_pkg::*;
(
  input  wire logic [15:0]                  ref_in,
  input  wire dsrs_pkg::dsrs_band_type [2:0] bands,
  output dsrs_pkg::dsrs_skip_type            result
);
  logic [15:0] lo_u;
  logic [15:0] hi_u;
  logic        hit;

  always_comb
  begin
    lo_u = ref_in;
    hi_u = ref_in;
    hit  = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      if (dsrs_in_band(ref_in, bands[i]))
      begin
        hit = 1'b1;
        if (bands[i].lo < lo_u) lo_u = bands[i].lo;
        if (bands[i].hi > hi_u) hi_u = bands[i].hi;
      end
    end
    // two more passes merge chains of overlapping bands
    for (int p = 0; p < 2; p++)
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (hit && (bands[i].lo < bands[i].hi) && (bands[i].lo <= hi_u)
            && (bands[i].hi >= lo_u))
        begin
          if (bands[i].lo < lo_u) lo_u = bands[i].lo;
          if (bands[i].hi > hi_u) hi_u = bands[i].hi;
        end
      end
    end
    result.hit = hit;
    // nearer edge wins, a tie goes low
    if (hit && ((ref_in - lo_u) <= (hi_u - ref_in)))
      result.value = lo_u;
    else if (hit)
      result.value = hi_u;
    else
      result.value = ref_in;
  end

endmodule

// ===== dsrs_switch_model.sv
// operator switch model driving the terminal inputs
`timescale 1ns/1ps
module dsrs_switch_model (
  input  wire logic       clk,
  input  wire logic [5:0] switch_set,
  output logic      [5:0] terminal_in
);
  // contacts move just after an edge; the design's own synchronisers absorb them
  always @(posedge clk)
  begin
    terminal_in <= switch_set;
  end
endmodule

// ===== dsrs_top.sv
// speed reference select: presets, up/down pot reference, skip bands
//
// Contract
// - preset select sources: off or terminal inputs
// - no select bits: pass normal place reference
// - select bits form binary preset number
// - seven programmable presets with set defaults
// - inactive select reads zero; two-bit use
// - increase/decrease sources: off or terminal inputs
// - pot drives reference when place source five
// - mode zero: stop clears pot value
// - mode one: keep value, ignore standstill commands
// - mode two: pot tracks active reference
// - mode three: keep value, standstill changes allowed
// - pot full-scale ramp time 0.1 to 320 s
// - three bands with bottom and top
// - steady reference never inside a band
// - suppression off while accelerating or decelerating
// - overlapping bands excluded as their union
`timescale 1ns/1ps
`include "dsrs_params.svh"
module dsrs_top #(
  parameter logic [15:0] REF_MAX  = `DSRS_REF_MAX,
  parameter int unsigned TICK_CYC = (`DSRS_RAMP_UNIT_NS / `DSRS_CLK_NS) / REF_MAX
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [31:0] wb_dat_w,
  input  wire logic [3:0]  wb_sel,
  output logic      [31:0] wb_dat_r,
  output logic             wb_ack,
  input  wire logic [5:0]  terminal_in,
  input  wire logic        drive_run,
  input  wire logic        ramp_active,
  input  wire logic [15:0] normal_ref,
  output logic      [15:0] freq_ref,
  output logic             preset_active
);
  import dsrs_pkg::*;

  localparam logic [6:0][15:0] PRESET_RST = {`DSRS_PRESET7_RST, `DSRS_PRESET6_RST,
    `DSRS_PRESET5_RST, `DSRS_PRESET4_RST, `DSRS_PRESET3_RST, `DSRS_PRESET2_RST,
    `DSRS_PRESET1_RST};

  logic [31:0]              src_reg, src_next;
  logic [31:0]              pot_cfg_reg, pot_cfg_next;
  logic [6:0][15:0]         preset_reg, preset_next;
  dsrs_band_type [2:0]      band_reg, band_next;
  logic                     ack_reg, ack_next;
  logic [31:0]              rdata_reg, rdata_next;
  logic [5:0]               ti_meta_reg, ti_reg;
  logic [15:0]              pot_reg, pot_next;
  logic [31:0]              tick_cnt_reg, tick_cnt_next;
  logic [15:0]              step_cnt_reg, step_cnt_next;
  logic                     run_prev_reg;
  logic [15:0]              freq_reg, freq_next;
  logic                     preset_reg_act, preset_act_next;

  logic [5:0]               idx;
  logic                     wr_req, rd_req;
  logic [31:0]              merged;
  logic [2:0]               code;
  logic                     inc_cmd, dec_cmd, pot_sel, tick, step, allow;
  logic [1:0]               pot_mode;
  logic [15:0]              ramp_time, ref_pre;
  dsrs_skip_type            skipped;

  // route a terminal input to a logical signal; 0 and 7 give an idle low
  function automatic logic sel_input(input logic [2:0] src, input logic [5:0] ti);
    if (src == 3'h0 || src == 3'h7)
      sel_input = 1'b0;
    else
      sel_input = ti[src - 3'h1];
  endfunction

  function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
    merge_lanes = old_v;
    for (int b = 0; b < 4; b++)
      if (sel[b]) merge_lanes[8*b +: 8] = new_v[8*b +: 8];
  endfunction

  assign idx    = wb_adr[7:2];
  assign wr_req = wb_cyc && wb_stb && wb_we && !ack_reg;
  assign rd_req = wb_cyc && wb_stb && !wb_we && !ack_reg;
  assign wb_ack   = ack_reg;
  assign wb_dat_r = rdata_reg;
  assign freq_ref = freq_reg;
  assign preset_active = preset_reg_act;

  // pins come from switches: two flops before any logic looks at them
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ti_meta_reg <= 6'h00;
      ti_reg      <= 6'h00;
    end
    else
    begin
      ti_meta_reg <= terminal_in;
      ti_reg      <= ti_meta_reg;
    end
  end

  // selection signals and the reference path
  always_comb
  begin
    code[0] = sel_input(src_reg[`DSRS_SEL0_LSB +: 3], ti_reg);
    code[1] = sel_input(src_reg[`DSRS_SEL1_LSB +: 3], ti_reg);
    code[2] = sel_input(src_reg[`DSRS_SEL2_LSB +: 3], ti_reg);
    inc_cmd = sel_input(src_reg[`DSRS_INC_LSB +: 3], ti_reg);
    dec_cmd = sel_input(src_reg[`DSRS_DEC_LSB +: 3], ti_reg);
    pot_mode  = pot_cfg_reg[`DSRS_MODE_LSB +: 2];
    pot_sel   = (pot_cfg_reg[`DSRS_PLACE_LSB +: 3] == `DSRS_PLACE_POT);
    ramp_time = pot_cfg_reg[`DSRS_RAMP_LSB +: 16];
    if (code != 3'h0)
      ref_pre = preset_reg[code - 3'h1];
    else if (pot_sel)
      ref_pre = pot_reg;
    else
      ref_pre = normal_ref;
    // the ramp is left to cross bands; only a settled target is moved
    freq_next       = ramp_active ? ref_pre : skipped.value;
    preset_act_next = (code != 3'h0);
  end

  dsrs_skip u_skip (
    .ref_in (ref_pre),
    .bands  (band_reg),
    .result (skipped)
  );

  // register file over classic Wishbone, one wait state on every access
  always_comb
  begin
    src_next     = src_reg;
    pot_cfg_next = pot_cfg_reg;
    preset_next  = preset_reg;
    band_next    = band_reg;
    ack_next     = wb_cyc && wb_stb && !ack_reg;
    rdata_next   = rdata_reg;
    merged       = 32'h0000_0000;
    if (wr_req)
    begin
      if (idx == `DSRS_IDX_SRC)
        src_next = merge_lanes(src_reg, wb_dat_w, wb_sel);
      if (idx == `DSRS_IDX_POT)
      begin
        merged = merge_lanes(pot_cfg_reg, wb_dat_w, wb_sel);
        // out-of-range ramp time is pulled to the nearest legal figure
        if (merged[`DSRS_RAMP_LSB +: 16] < `DSRS_RAMP_MIN)
          merged[`DSRS_RAMP_LSB +: 16] = `DSRS_RAMP_MIN;
        else if (merged[`DSRS_RAMP_LSB +: 16] > `DSRS_RAMP_MAX)
          merged[`DSRS_RAMP_LSB +: 16] = `DSRS_RAMP_MAX;
        pot_cfg_next = merged;
      end
      for (int i = 0; i < `DSRS_NUM_PRESET; i++)
        if (idx == `DSRS_IDX_PRESET + 6'(i))
          preset_next[i] = 16'(merge_lanes({16'h0000, preset_reg[i]}, wb_dat_w, wb_sel));
      for (int i = 0; i < `DSRS_NUM_BAND; i++)
        if (idx == `DSRS_IDX_BAND + 6'(i))
          band_next[i] = merge_lanes(band_reg[i], wb_dat_w, wb_sel);
    end
    if (rd_req)
    begin
      rdata_next = 32'h0000_0000;
      if (idx == `DSRS_IDX_SRC)
        rdata_next = src_reg;
      if (idx == `DSRS_IDX_POT)
        rdata_next = pot_cfg_reg;
      for (int i = 0; i < `DSRS_NUM_PRESET; i++)
        if (idx == `DSRS_IDX_PRESET + 6'(i))
          rdata_next = {16'h0000, preset_reg[i]};
      for (int i = 0; i < `DSRS_NUM_BAND; i++)
        if (idx == `DSRS_IDX_BAND + 6'(i))
          rdata_next = band_reg[i];
      if (idx == `DSRS_IDX_STATUS)
        rdata_next = {12'h000, pot_sel, code, freq_reg};
      if (idx == `DSRS_IDX_POTVAL)
        rdata_next = {16'h0000, pot_reg};
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      src_reg        <= `DSRS_SRC_RST;
      pot_cfg_reg    <= `DSRS_POT_RST;
      preset_reg     <= PRESET_RST;
      band_reg       <= {`DSRS_BAND_RST, `DSRS_BAND_RST, `DSRS_BAND_RST};
      ack_reg        <= 1'b0;
      rdata_reg      <= 32'h0000_0000;
      freq_reg       <= `DSRS_REF_ZERO;
      preset_reg_act <= 1'b0;
    end
    else
    begin
      src_reg        <= src_next;
      pot_cfg_reg    <= pot_cfg_next;
      preset_reg     <= preset_next;
      band_reg       <= band_next;
      ack_reg        <= ack_next;
      rdata_reg      <= rdata_next;
      freq_reg       <= freq_next;
      preset_reg_act <= preset_act_next;
    end
  end

  // up/down pot: one LSB per (ramp_time x tick), so full scale takes ramp_time x 0.1 s
  always_comb
  begin
    tick          = (tick_cnt_reg == TICK_CYC - 1);
    tick_cnt_next = tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
    step          = tick && (step_cnt_reg >= ramp_time - 16'h0001);
    step_cnt_next = step_cnt_reg;
    if (inc_cmd == dec_cmd)
      step_cnt_next = 16'h0000;  // restart timing so each press starts clean
    else if (step)
      step_cnt_next = 16'h0000;
    else if (tick)
      step_cnt_next = step_cnt_reg + 16'h0001;
    allow    = !(pot_mode == `DSRS_MODE_KEEP && !drive_run);
    pot_next = pot_reg;
    if (pot_mode == `DSRS_MODE_RESET && run_prev_reg && !drive_run)
      pot_next = `DSRS_REF_ZERO;
    else if (pot_mode == `DSRS_MODE_TRACK && !pot_sel)
      pot_next = (ref_pre > REF_MAX) ? REF_MAX : ref_pre;
    else if (step && allow && inc_cmd && !dec_cmd && pot_reg < REF_MAX)
      pot_next = pot_reg + 16'h0001;
    else if (step && allow && dec_cmd && !inc_cmd && pot_reg > `DSRS_REF_ZERO)
      pot_next = pot_reg - 16'h0001;
    else if (pot_reg > REF_MAX)
      pot_next = REF_MAX;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pot_reg      <= `DSRS_REF_ZERO;
      tick_cnt_reg <= 32'h0000_0000;
      step_cnt_reg <= 16'h0000;
      run_prev_reg <= 1'b0;
    end
    else
    begin
      pot_reg      <= pot_next;
      tick_cnt_reg <= tick_cnt_next;
      step_cnt_reg <= step_cnt_next;
      run_prev_reg <= drive_run;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_off_source_low: assert property (
    (src_reg[`DSRS_SEL0_LSB +: 3] == 3'h0) |-> !code[0])
    else $error("inactive select signal not low");

  a_normal_pass: assert property (
    (code == 3'h0 && !pot_sel && ramp_active) |=> (freq_reg == $past(normal_ref)))
    else $error("normal reference not passed through");

  a_preset_seven: assert property (
    (code == 3'h7 && ramp_active) |=> (freq_reg == $past(preset_reg[6])))
    else $error("code seven did not select preset seven");

  a_preset_defaults: assert property (
    $past(sys_rst) |-> (preset_reg[0] == `DSRS_PRESET1_RST
                        && preset_reg[6] == `DSRS_PRESET7_RST))
    else $error("preset reset defaults wrong");

  a_two_bit_use: assert property (
    (src_reg[`DSRS_SEL2_LSB +: 3] == 3'h0) |-> (code <= 3'h3))
    else $error("third select signal active while off");

  a_pot_drives: assert property (
    (code == 3'h0 && pot_sel && ramp_active) |=> (freq_reg == $past(pot_reg)))
    else $error("pot value not used as reference");

  a_stop_clears: assert property (
    (pot_mode == `DSRS_MODE_RESET && run_prev_reg && !drive_run) |=> (pot_reg == 16'h0000))
    else $error("stop did not clear pot value");

  a_standstill_hold: assert property (
    (pot_mode == `DSRS_MODE_KEEP && !drive_run && pot_reg <= REF_MAX) |=> $stable(pot_reg))
    else $error("pot changed at standstill in keep mode");

  a_track_ref: assert property (
    (pot_mode == `DSRS_MODE_TRACK && !pot_sel && ref_pre <= REF_MAX)
      |=> (pot_reg == $past(ref_pre)))
    else $error("pot not tracking active reference");

  a_ramp_range: assert property (
    (ramp_time >= `DSRS_RAMP_MIN) && (ramp_time <= `DSRS_RAMP_MAX))
    else $error("ramp time out of range");

  a_settle_outside: assert property (
    !ramp_active |=> !(dsrs_in_band(freq_reg, band_reg[0]) || dsrs_in_band(freq_reg, band_reg[1])
                       || dsrs_in_band(freq_reg, band_reg[2])))
    else $error("reference settled inside a skip band");

  a_ramp_bypass: assert property (
    ramp_active |=> (freq_reg == $past(ref_pre)))
    else $error("band suppression active during ramp");

  a_pot_clamped: assert property (
    (pot_reg <= REF_MAX) |=> (pot_reg <= REF_MAX))
    else $error("pot left its range");

endmodule

// ===== dsrs_top_tb_top.sv
// self-checking bench for the speed reference select block
`timescale 1ns/1ps
`include "dsrs_params.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] t=%0t got=%0h exp=%0h", $time, a, b); end end
module dsrs_top_tb_top;
  logic        clk         = 1'b0;
  logic        sys_rst     = 1'b1;
  logic        wb_cyc      = 1'b0;
  logic        wb_stb      = 1'b0;
  logic        wb_we       = 1'b0;
  logic [7:0]  wb_adr      = 8'h00;
  logic [31:0] wb_dat_w    = 32'h0000_0000;
  logic [3:0]  wb_sel      = 4'hF;
  logic [3:0]  lanes       = 4'hF;
  logic [31:0] wb_dat_r;
  logic        wb_ack;
  logic [5:0]  switch_set  = 6'h00;
  logic [5:0]  terminal_in;
  logic        drive_run   = 1'b0;
  logic        ramp_active = 1'b0;
  logic [15:0] normal_ref  = 16'h0000;
  logic [15:0] freq_ref;
  logic        preset_active;
  int          err_count   = 0;
  int          n_compared  = 0;
  int          k;
  logic [31:0] rd;
  logic [15:0] v;
  logic [15:0] w;
  logic [15:0] pre_exp [0:6] = '{`DSRS_PRESET1_RST, `DSRS_PRESET2_RST, `DSRS_PRESET3_RST,
    `DSRS_PRESET4_RST, `DSRS_PRESET5_RST, `DSRS_PRESET6_RST, `DSRS_PRESET7_RST};

  always #20 clk = ~clk;

  // short ramp tick so a full-scale pot sweep fits in a few thousand cycles
  dsrs_top #(.TICK_CYC(4)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_dat_w(wb_dat_w), .wb_sel(wb_sel), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .terminal_in(terminal_in), .drive_run(drive_run),
    .ramp_active(ramp_active), .normal_ref(normal_ref), .freq_ref(freq_ref),
    .preset_active(preset_active)
  );

  dsrs_switch_model sw_u (.clk(clk), .switch_set(switch_set), .terminal_in(terminal_in));

  task automatic results();
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int i;
    @(posedge clk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= adr;
    wb_dat_w <= dat;
    wb_sel   <= lanes;
    for (i = 0; i < 16; i++)
    begin
      @(posedge clk);
      if (wb_ack === 1'b1)
        break;
    end
    if (i == 16)
    begin
      err_count++;
      results();
    end
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic rd_val(input logic [7:0] adr);
    bus(1'b0, adr, 32'h0000_0000);
    v = rd[15:0];
  endtask

  task automatic ref_chk(input logic [15:0] nr, input logic ra, input logic [15:0] exp);
    normal_ref  <= nr;
    ramp_active <= ra;
    hold(4);
    `CHK(freq_ref, exp)
  endtask

  // operator holds a switch pattern for n cycles, then lets go; leaves pot value in v
  task automatic press(input logic [5:0] pat, input int n);
    switch_set <= pat;
    hold(n);
    switch_set <= 6'h00;
    hold(4);
    rd_val(8'h34);
  endtask

  initial
  begin
    hold(100000);
    err_count++;
    results();
  end

  initial
  begin
    hold(6);
    sys_rst <= 1'b0;
    hold(1);
    bus(1'b0, 8'h00, 32'h0);
    `CHK(rd, `DSRS_SRC_RST)
    bus(1'b0, 8'h04, 32'h0);
    `CHK(rd, `DSRS_POT_RST)
    for (k = 0; k < 7; k++)
    begin
      rd_val(8'(8'h08 + 4 * k));
      `CHK(v, pre_exp[k])
    end
    bus(1'b0, 8'h2C, 32'h0);
    `CHK(rd, `DSRS_BAND_RST)
    bus(1'b0, 8'hFC, 32'h0);
    `CHK(rd, 32'h0000_0000)
    ref_chk(16'h007B, 1'b0, 16'h007B);
    `CHK(preset_active, 1'b0)
    // input four stays unused so its fault-reset duty is never disturbed
    bus(1'b1, 8'h00, 32'h0003_1265);
    // ramp flag up so the preset path is watched unsuppressed
    ramp_active <= 1'b1;
    for (k = 1; k < 8; k++)
    begin
      switch_set <= {k[1], k[0], 2'b00, k[2], 1'b0};
      hold(5);
      `CHK(freq_ref, pre_exp[k - 1])
      `CHK(preset_active, 1'b1)
    end
    bus(1'b1, 8'h00, 32'h0003_1065);
    switch_set <= 6'h12;
    hold(5);
    `CHK(freq_ref, pre_exp[0])
    switch_set <= 6'h00;
    bus(1'b1, 8'h24, 32'h012C_00C8);
    bus(1'b1, 8'h28, 32'h015E_0118);
    bus(1'b1, 8'h2C, 32'h0064_01F4);
    ref_chk(16'h00FA, 1'b0, 16'h00C8);
    ref_chk(16'h0140, 1'b0, 16'h015E);
    ref_chk(16'h0113, 1'b0, 16'h00C8);
    ref_chk(16'h0140, 1'b1, 16'h0140);
    ref_chk(16'h00C8, 1'b0, 16'h00C8);
    ref_chk(16'h0050, 1'b0, 16'h0050);
    ref_chk(16'h0000, 1'b0, 16'h0000);
    // pot path watched with band suppression bypassed
    ramp_active <= 1'b1;
    bus(1'b1, 8'h04, 32'h0000_0053);
    bus(1'b0, 8'h04, 32'h0);
    `CHK(rd, 32'h0001_0053)
    bus(1'b1, 8'h04, 32'hFFFF_0053);
    bus(1'b0, 8'h04, 32'h0);
    `CHK(rd, 32'h0C80_0053)
    bus(1'b1, 8'h04, 32'h0001_0053);
    press(6'h01, 40);
    `CHK(v inside {[16'h0009:16'h000B]}, 1'b1)
    w = v;
    bus(1'b0, 8'h30, 32'h0);
    `CHK(rd[15:0], w)
    `CHK(rd[19], 1'b1)
    press(6'h05, 20);
    `CHK(v, w)
    press(6'h04, 60);
    `CHK(v, 16'h0000)
    press(6'h01, 2100);
    `CHK(v, `DSRS_REF_MAX)
    bus(1'b1, 8'h04, 32'h0001_0051);
    press(6'h04, 40);
    `CHK(v, `DSRS_REF_MAX)
    drive_run <= 1'b1;
    press(6'h04, 40);
    `CHK(v < `DSRS_REF_MAX, 1'b1)
    w = v;
    bus(1'b1, 8'h04, 32'h0001_0053);
    hold(2);
    drive_run <= 1'b0;
    hold(4);
    rd_val(8'h34);
    `CHK(v, w)
    press(6'h01, 40);
    `CHK(v > w, 1'b1)
    bus(1'b1, 8'h04, 32'h0001_0050);
    drive_run <= 1'b1;
    hold(2);
    drive_run <= 1'b0;
    hold(4);
    rd_val(8'h34);
    `CHK(v, 16'h0000)
    bus(1'b1, 8'h04, 32'h0001_0002);
    normal_ref <= 16'h0096;
    hold(4);
    rd_val(8'h34);
    `CHK(v, 16'h0096)
    `CHK(freq_ref, 16'h0096)
    // one byte lane only: the upper lanes of preset seven must survive
    lanes = 4'h1;
    bus(1'b1, 8'h20, 32'hFFFF_FF11);
    lanes = 4'hF;
    bus(1'b0, 8'h20, 32'h0);
    `CHK(rd, 32'h0000_0111)
    results();
  end
endmodule
